// ---- bench/fci_host.sv ----
/* Host model: an APB master that issues one transfer per call.
   Assumes the caller enters xfer just after a rising pclk edge. */
`timescale 1ns/10ps

module fci_host (
    // Clock
    input  wire        pclk,
    // APB master side
    output logic       psel,
    output logic       penable,
    output logic       pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    // Idle bus from time zero.
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end

    // Setup, access until ready, then release with stale values inverted.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        paddr   <= ~a;
        pwdata  <= ~d;
        @(posedge pclk);
    endtask
endmodule

// ---- bench/fci_top_sva.sv ----
/* Checker for fci_top: APB answer timing, refusals and identifier reads.
   Assumes a bind onto fci_top and a host that keeps the APB rules. */
`timescale 1ns/10ps
`include "fci_defines.vh"

module fci_top_sva (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB slave side
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Completed transfers and the decode of the address map.
    reg  [7:0]  cmd_q;
    reg  [11:0] ptr_q;
    wire        done_w = pready && psel && penable;
    wire        rdd_w  = done_w && !pwrite && paddr == `FCI_REG_DATA;
    wire        map_w  = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};

    // Last accepted command byte and read pointer, as the host sees them.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= `FCI_CMD_READ_ARRAY;
            ptr_q <= 12'h000;
        end else if (done_w && pwrite && paddr == `FCI_REG_CMD) begin
            cmd_q <= pwdata[7:0];
            ptr_q <= pwdata[19:8];
        end else if (done_w && pwrite && paddr == `FCI_REG_DATA) begin
            ptr_q <= pwdata[11:0];
        end
    end

    // ------------------------------------------------------------
    // Steps of a transfer and the properties built on them
    // ------------------------------------------------------------
    sequence s_setup_wr; psel && !penable && pwrite; endsequence
    sequence s_setup_rd; psel && !penable && !pwrite; endsequence
    sequence s_rd_answer; !pready ##1 pready; endsequence

    AST_WR_ANSWER:
        assert property (s_setup_wr |=> pready)
        else $error("write not answered in the first access cycle");
    AST_RD_ANSWER:
        assert property (s_setup_rd |=> s_rd_answer)
        else $error("read not answered after one wait cycle");
    AST_RDY_PULSE:
        assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_RDY_IN_ACCESS:
        assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    AST_ERR_UNMAPPED:
        assert property (done_w && !map_w |-> pslverr)
        else $error("unmapped address not refused");
    AST_ERR_MAPPED:
        assert property (pslverr |-> pready && map_w == 1'b0)
        else $error("error response on a mapped address");
    AST_ID_MAKER:
        assert property (rdd_w && cmd_q == `FCI_CMD_READ_ID && ptr_q == `FCI_ID_MAKER_ADR
                         |-> prdata[7:0] == `FCI_ID_MAKER)
        else $error("maker code wrong in identifier mode");
    AST_ID_DEVICE:
        assert property (rdd_w && cmd_q == `FCI_CMD_READ_ID && ptr_q == `FCI_ID_DEV_ADR
                         |-> prdata[7:0] == `FCI_ID_DEVICE)
        else $error("device code wrong in identifier mode");
endmodule

// ---- bench/flash_command_interpreter_bench.sv ----
/* Bench for the flash command interpreter: commands go through the host
   model; status, array and identifier reads are compared.
   Assumes fci_top, fci_host and fci_top_sva are compiled first. */
`timescale 1ns/10ps
`include "fci_defines.vh"

module flash_command_interpreter_bench;
    localparam logic [31:0] sr_rdy = 32'h1 << `FCI_SR_READY, sr_es = 32'h1 << `FCI_SR_ESUSP,
        sr_ee = 32'h1 << `FCI_SR_ERASE_ERR, sr_pe = 32'h1 << `FCI_SR_PROG_ERR,
        sr_ps = 32'h1 << `FCI_SR_PSUSP, sr_pr = 32'h1 << `FCI_SR_PROTECT;
    logic        pclk, presetn, top_pin_n, other_pin_n, e;
    logic [31:0] q;
    wire         psel, penable, pwrite, pready, pslverr;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    int          mismatches, comparisons, cycles;

    fci_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    fci_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .top_sector_protect_pin_n(top_pin_n),
        .other_sector_protect_pin_n(other_pin_n));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    // A hang ends the run as a failure.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            mismatches++;
            print_verdict;
        end
    end

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'h1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a);
        u_host.xfer(1'h0, a, 32'h0, q, e);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [11:0] a);
        wr(`FCI_REG_CMD, {12'h000, a, c});
    endtask
    task automatic prog(input logic [11:0] a, input logic [7:0] d);
        cmd(`FCI_CMD_PROG_SETUP_A, a);
        cmd(d, a);
    endtask
    task automatic poll(input logic [31:0] m);
        do rd(`FCI_REG_STATUS); while ((q & m) !== m);
    endtask
    task automatic st(input logic [31:0] x);
        rd(`FCI_REG_STATUS);
        check("status", q & 32'hff, x);
    endtask
    task automatic peek(input logic [11:0] a);
        wr(`FCI_REG_DATA, {20'h0, a});
        rd(`FCI_REG_DATA);
    endtask
    task automatic look(input logic [11:0] a);
        cmd(`FCI_CMD_READ_ARRAY, a);
        peek(a);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'h0;
        top_pin_n = 1'h1;
        other_pin_n = 1'h1;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        st(sr_rdy);
        rd(`FCI_REG_LOCK);
        check("lock", q, {16'h0, `FCI_LOCK_RESET});
        rd(12'h014);
        check("slverr", {31'h0, e}, 32'h1);
        prog(12'h210, 8'h3c);
        poll(sr_rdy);
        st(sr_rdy | sr_pe | sr_pr);
        cmd(`FCI_CMD_CLEAR_STATUS, 12'h000);
        st(sr_rdy);
        wr(`FCI_REG_LOCK, 32'h0);
        rd(`FCI_REG_LOCK);
        check("lock", q, 32'h0);
        top_pin_n <= 1'h0;
        repeat (4) @(posedge pclk);
        rd(`FCI_REG_PINS);
        check("pins", q, 32'h1);
        prog(12'hf00, 8'h00);
        poll(sr_rdy);
        st(sr_rdy | sr_pe | sr_pr);
        cmd(`FCI_CMD_CLEAR_STATUS, 12'h000);
        top_pin_n <= 1'h1;
        cmd(`FCI_CMD_ERASE_SETUP, 12'h200);
        cmd(8'h77, 12'h200);
        st(sr_rdy | sr_ee | sr_pe);
        rd(`FCI_REG_DATA);
        check("data mode", q & 32'hff, sr_rdy | sr_ee | sr_pe);
        cmd(`FCI_CMD_CLEAR_STATUS, 12'h000);
        cmd(`FCI_CMD_ERASE_SETUP, 12'h2a0);
        cmd(`FCI_CMD_CONFIRM, 12'h2a0);
        cmd(`FCI_CMD_READ_ARRAY, 12'h000);
        rd(`FCI_REG_DATA);
        check("busy", q & sr_rdy, 32'h0);
        poll(sr_rdy);
        st(sr_rdy);
        look(12'h2ff);
        check("erased", q & 32'hff, 32'hff);
        prog(12'h200, 8'h5a);
        rd(`FCI_REG_DATA);
        check("prog mode", q & sr_rdy, 32'h0);
        poll(sr_rdy);
        st(sr_rdy);
        cmd(`FCI_CMD_PROG_SETUP_B, 12'h200);
        cmd(8'hff, 12'h200);
        poll(sr_rdy);
        st(sr_rdy);
        look(12'h200);
        check("array", q & 32'hff, 32'h5a);
        cmd(`FCI_CMD_READ_ID, 12'h000);
        peek(`FCI_ID_MAKER_ADR);
        check("maker", q & 32'hff, {24'h0, `FCI_ID_MAKER});
        peek(`FCI_ID_DEV_ADR);
        check("device", q & 32'hff, {24'h0, `FCI_ID_DEVICE});
        cmd(`FCI_CMD_READ_STATUS, 12'h000);
        rd(`FCI_REG_DATA);
        check("status mode", q & 32'hff, sr_rdy);
        prog(12'h220, 8'h00);
        cmd(`FCI_CMD_PROG_SUSP, 12'h000);
        poll(sr_ps);
        st(sr_rdy | sr_ps);
        cmd(`FCI_CMD_CONFIRM, 12'h000);
        poll(sr_rdy);
        st(sr_rdy);
        cmd(`FCI_CMD_ERASE_SETUP, 12'h100);
        cmd(`FCI_CMD_CONFIRM, 12'h100);
        cmd(`FCI_CMD_ERASE_SUSP, 12'h000);
        poll(sr_es);
        st(sr_rdy | sr_es);
        prog(12'h210, 8'h3c);
        poll(sr_rdy);
        st(sr_rdy | sr_es);
        look(12'h210);
        check("array", q & 32'hff, 32'h3c);
        cmd(`FCI_CMD_CONFIRM, 12'h100);
        rd(`FCI_REG_STATUS);
        check("resume", q & (sr_rdy | sr_es), 32'h0);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        peek(12'h200);
        check("array", q & 32'hff, 32'h5a);
        print_verdict;
    end
endmodule

bind fci_top fci_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

// ---- common/fci_defines.vh ----
/*
 * Command codes, status bits, register map, geometry and timing of
 * the flash command interpreter; included by bare name.
 */
`ifndef FCI_DEFINES_VH
`define FCI_DEFINES_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define FCI_CMD_READ_ARRAY   8'hff
`define FCI_CMD_ERASE_SETUP  8'h20
`define FCI_CMD_CONFIRM      8'hd0
`define FCI_CMD_PROG_SETUP_A 8'h40
`define FCI_CMD_PROG_SETUP_B 8'h10
`define FCI_CMD_ERASE_SUSP   8'hb0
`define FCI_CMD_PROG_SUSP    8'hb0
`define FCI_CMD_READ_ID      8'h90
`define FCI_CMD_READ_STATUS  8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define FCI_SR_READY     7
`define FCI_SR_ESUSP     6
`define FCI_SR_ERASE_ERR 5
`define FCI_SR_PROG_ERR  4
`define FCI_SR_PSUSP     2
`define FCI_SR_PROTECT   1

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define FCI_REG_CMD      12'h000
`define FCI_REG_DATA     12'h004
`define FCI_REG_STATUS   12'h008
`define FCI_REG_LOCK     12'h00c
`define FCI_REG_PINS     12'h010
`define FCI_LOCK_RESET   16'hffff

// ----------------------------------------------------------------
// Geometry and identifier codes
// ----------------------------------------------------------------
`define FCI_AW           12
`define FCI_SEC_MSB      11
`define FCI_SEC_LSB      8
`define FCI_NSEC         16
`define FCI_TOP_SECTOR   4'hf
`define FCI_ID_MAKER_ADR 12'h000
`define FCI_ID_DEV_ADR   12'h001
`define FCI_ID_MAKER     8'h5a
`define FCI_ID_DEVICE    8'ha5

// ----------------------------------------------------------------
// Operation timing in pclk cycles
// ----------------------------------------------------------------
`define FCI_PROG_CYC     8'd20
`define FCI_ERASE_STEP   8'd255
`define FCI_ZERO8        8'h00
`define FCI_ONE8         8'h01

`endif

// ---- rtl/fci_array.v ----
/*
 * Flash array model memory: one byte per address with registered read
 * data and a write port used by program and sector erase steps.
 * Assumes a single pclk domain and an owner that sequences writes.
 */
`timescale 1ns/10ps
`include "fci_defines.vh"

module fci_array (
    // Clock
    input  wire                 pclk,
    // Read port
    input  wire [`FCI_AW-1:0]   raddr,
    output reg  [7:0]           rdata,
    // Write port
    input  wire                 we,
    input  wire [`FCI_AW-1:0]   waddr,
    input  wire [7:0]           wdata
);

    reg [7:0] mem [0:(1<<`FCI_AW)-1];

    // Writes store the byte; reads come out of a register.
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// ---- rtl/fci_top.v ----
/*
 * Flash command interpreter with its write state machine, reached over
 * APB. Writes to CMD carry a command byte at the array address; reads
 * of DATA return array, status or identifier according to read mode.
 * Assumes one 40 MHz pclk and protect pins synchronised here.
 */
// Behaviour
// (R1) Reset leaves the device in array read.
// (R2) Write FF selects array read mode.
// (R3) Array read ignored while operation runs.
// (R4) Erase needs 20 then D0 in sector.
// (R5) Program setup 40 or 10, then data.
// (R6) Erased reads one; program only clears bits.
// (R7) Locked or protected sector aborts, flags status.
// (R8) After program sequence reads return status.
// (R9) Verify fails only when a zero stays one.
// (R10) Erase suspend pauses at step, status reads.
// (R11) Erase suspend limits accepted commands.
// (R12) D0 resumes erase after suspended program.
// (R13) Program suspend pauses, reads give status.
// (R14) Program suspend allows read, status, resume.
// (R15) Write 70 selects status read.
// (R16) Errors set by machine, cleared by 50.
// (R17) Command 90 gives identifier reads.
// (R18) Host clears status after program error.
// (R19) Host keeps reset high while suspended.
// (R20) Status bit 7 shows ready.
// (R21) Bad erase sequence sets both errors.
// (R22) Protect bit set on lock abort.
// (R23) Bad second write sets errors, status mode.
// (R24) Other commands ignored while busy.
`timescale 1ns/10ps
`include "fci_defines.vh"

module fci_top (
    // APB clock and reset
    input  wire                 pclk,
    input  wire                 presetn,
    // APB slave
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [11:0]          paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output reg                  pready,
    output reg                  pslverr,
    // Hardware protect pins, active low
    input  wire                 top_sector_protect_pin_n,
    input  wire                 other_sector_protect_pin_n
);

    // Read modes and machine states, one-hot.
    localparam [2:0] RM_ARRAY = 3'b001, RM_STATUS = 3'b010, RM_ID = 3'b100;
    localparam [5:0] ST_IDLE  = 6'b000001, ST_PROG  = 6'b000010,
                     ST_ERASE = 6'b000100, ST_PSUSP = 6'b001000,
                     ST_ESUSP = 6'b010000, ST_EPROG = 6'b100000;

    // ------------------------------------------------------------
    // Registers and wires
    // ------------------------------------------------------------
    reg  [2:0]          rmode_q;
    reg  [5:0]          state_q;
    reg  [1:0]          pend_q;      // 01 erase setup, 10 program setup
    reg  [`FCI_AW-1:0]  addr_q;      // current target address
    reg  [`FCI_AW-1:0]  eaddr_q;     // suspended erase sector
    reg  [7:0]          pdata_q;
    reg  [7:0]          cnt_q;
    reg  [`FCI_AW-1:0]  eptr_q;      // erase walk pointer
    reg                 suspreq_q;
    reg                 esusp_q, psusp_q, eerr_q, perr_q, prot_q;
    reg  [`FCI_NSEC-1:0] lock_q;
    reg  [`FCI_AW-1:0]  dptr_q;      // address for DATA reads
    reg  [1:0]          tp_sync_q, op_sync_q;
    reg                 vchk_q;      // verify read pending
    reg                 rd_wait_q;

    wire                setup  = psel & ~penable;
    wire                wr_cmd = setup & pwrite & (paddr == `FCI_REG_CMD);
    wire [7:0]          cmd    = pwdata[7:0];
    wire [`FCI_AW-1:0]  caddr  = pwdata[8+`FCI_AW-1:8];
    wire                busy   = state_q[1] | state_q[2] | state_q[5];
    wire [7:0]          status = {~busy, esusp_q, eerr_q, perr_q, 1'b0,
                                  psusp_q, prot_q, 1'b0};
    wire [7:0]          arr_rdata;
    reg                 arr_we;
    reg  [`FCI_AW-1:0]  arr_waddr;
    reg  [7:0]          arr_wdata;
    reg  [`FCI_AW-1:0]  arr_raddr;

    // Lock check of a sector against register bit and pins.
    function locked;
        input [`FCI_AW-1:0] a;
        reg   [3:0]         s;
        begin
            s = a[`FCI_SEC_MSB:`FCI_SEC_LSB];
            locked = lock_q[s] |
                     ((s == `FCI_TOP_SECTOR) ? ~tp_sync_q[1] : ~op_sync_q[1]);
        end
    endfunction

    // ------------------------------------------------------------
    // Array memory
    // ------------------------------------------------------------
    fci_array u_array (
        .pclk  (pclk),
        .raddr (arr_raddr),
        .rdata (arr_rdata),
        .we    (arr_we),
        .waddr (arr_waddr),
        .wdata (arr_wdata)
    );

    // Array port steering: erase writes ones, program ANDs in data.
    always @* begin
        arr_we    = 1'b0;
        arr_waddr = addr_q;
        arr_wdata = 8'hff;
        arr_raddr = (state_q == ST_PROG || state_q == ST_EPROG) ? addr_q : dptr_q;
        if (state_q == ST_ERASE && cnt_q == `FCI_ZERO8) begin
            arr_we    = 1'b1;
            arr_waddr = {eaddr_q[`FCI_SEC_MSB:`FCI_SEC_LSB], eptr_q[`FCI_SEC_LSB-1:0]};
            arr_wdata = 8'hff;                                   // R6
        end else if ((state_q == ST_PROG || state_q == ST_EPROG) &&
                     cnt_q == `FCI_ONE8 && !vchk_q) begin
            arr_we    = 1'b1;
            arr_wdata = arr_rdata & pdata_q;                     // R6
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tp_sync_q <= 2'b11;
            op_sync_q <= 2'b11;
        end else begin
            tp_sync_q <= {tp_sync_q[0], top_sector_protect_pin_n};
            op_sync_q <= {op_sync_q[0], other_sector_protect_pin_n};
        end
    end

    // ------------------------------------------------------------
    // Command interpreter and write state machine
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmode_q   <= RM_ARRAY;                               // R1
            state_q   <= ST_IDLE;
            pend_q    <= 2'b00;
            addr_q    <= {`FCI_AW{1'b0}};
            eaddr_q   <= {`FCI_AW{1'b0}};
            pdata_q   <= 8'hff;
            cnt_q     <= `FCI_ZERO8;
            eptr_q    <= {`FCI_AW{1'b0}};
            suspreq_q <= 1'b0;
            esusp_q   <= 1'b0;
            psusp_q   <= 1'b0;
            eerr_q    <= 1'b0;
            perr_q    <= 1'b0;
            prot_q    <= 1'b0;
            vchk_q    <= 1'b0;
        end else begin
            // Operation progress.
            case (state_q)
                ST_ERASE: begin
                    if (cnt_q != `FCI_ZERO8) begin
                        cnt_q <= cnt_q - `FCI_ONE8;
                    end else if (suspreq_q) begin
                        state_q   <= ST_ESUSP;                   // R10
                        esusp_q   <= 1'b1;
                        suspreq_q <= 1'b0;
                    end else if (&eptr_q[`FCI_SEC_LSB-1:0]) begin
                        state_q <= ST_IDLE;
                    end else begin
                        eptr_q <= eptr_q + 1'b1;
                    end
                end
                ST_PROG, ST_EPROG: begin
                    if (suspreq_q && state_q == ST_PROG && cnt_q > `FCI_ONE8) begin
                        state_q   <= ST_PSUSP;                   // R13
                        psusp_q   <= 1'b1;
                        suspreq_q <= 1'b0;
                    end else if (cnt_q > `FCI_ONE8) begin
                        cnt_q <= cnt_q - `FCI_ONE8;
                    end else if (!vchk_q) begin
                        vchk_q <= 1'b1;
                        cnt_q  <= `FCI_ZERO8;
                    end else if (cnt_q == `FCI_ZERO8) begin
                        cnt_q <= `FCI_ONE8;                      // wait read data
                    end else begin
                        vchk_q <= 1'b0;
                        if (|(arr_rdata & ~pdata_q))
                            perr_q <= 1'b1;                      // R9 R16
                        state_q <= (state_q == ST_EPROG) ? ST_ESUSP : ST_IDLE;
                    end
                end
                ST_IDLE: suspreq_q <= 1'b0;                      // Drops a late suspend.
                default: ;
            endcase

            // Host commands.
            if (wr_cmd) begin
                if (pend_q != 2'b00) begin
                    pend_q  <= 2'b00;
                    rmode_q <= RM_STATUS;                        // R8
                    if (pend_q[0] && cmd == `FCI_CMD_CONFIRM) begin
                        if (locked(caddr)) begin
                            prot_q <= 1'b1;                      // R7 R22
                            eerr_q <= 1'b1;
                        end else begin
                            state_q <= ST_ERASE;                 // R4
                            eaddr_q <= caddr;
                            eptr_q  <= {`FCI_AW{1'b0}};
                            cnt_q   <= `FCI_ERASE_STEP;
                        end
                    end else if (pend_q[1]) begin
                        if (locked(caddr) || (esusp_q &&
                            caddr[`FCI_SEC_MSB:`FCI_SEC_LSB] ==
                            eaddr_q[`FCI_SEC_MSB:`FCI_SEC_LSB])) begin
                            prot_q <= 1'b1;                      // R7 R11
                            perr_q <= 1'b1;
                        end else begin
                            addr_q  <= caddr;                    // R5
                            pdata_q <= cmd;
                            cnt_q   <= `FCI_PROG_CYC;
                            vchk_q  <= 1'b0;
                            state_q <= esusp_q ? ST_EPROG : ST_PROG;
                        end
                    end else begin
                        eerr_q <= 1'b1;                          // R21 R23
                        perr_q <= 1'b1;
                    end
                end else if (busy) begin
                    if (cmd == `FCI_CMD_READ_STATUS) begin
                        rmode_q <= RM_STATUS;                    // R15
                    end else if (cmd == `FCI_CMD_ERASE_SUSP && state_q != ST_EPROG) begin
                        suspreq_q <= 1'b1;                       // R10 R13
                        rmode_q   <= RM_STATUS;
                    end                                          // R3 R24
                end else if (state_q == ST_ESUSP || state_q == ST_PSUSP) begin
                    case (cmd)
                        `FCI_CMD_READ_ARRAY:  rmode_q <= RM_ARRAY;     // R11 R14
                        `FCI_CMD_READ_STATUS: rmode_q <= RM_STATUS;
                        `FCI_CMD_CONFIRM: begin
                            rmode_q <= RM_STATUS;
                            if (state_q == ST_ESUSP) begin
                                state_q <= ST_ERASE;             // R12
                                esusp_q <= 1'b0;
                            end else begin
                                state_q <= ST_PROG;              // R14
                                psusp_q <= 1'b0;
                            end
                        end
                        `FCI_CMD_PROG_SETUP_A, `FCI_CMD_PROG_SETUP_B: begin
                            if (state_q == ST_ESUSP) pend_q <= 2'b10;  // R11
                        end
                        default: ;
                    endcase
                end else begin
                    case (cmd)
                        `FCI_CMD_READ_ARRAY:   rmode_q <= RM_ARRAY;    // R2
                        `FCI_CMD_READ_STATUS:  rmode_q <= RM_STATUS;   // R15
                        `FCI_CMD_READ_ID:      rmode_q <= RM_ID;       // R17
                        `FCI_CMD_ERASE_SETUP:  pend_q  <= 2'b01;       // R4
                        `FCI_CMD_PROG_SETUP_A,
                        `FCI_CMD_PROG_SETUP_B: pend_q  <= 2'b10;       // R5
                        `FCI_CMD_CLEAR_STATUS: begin
                            eerr_q <= 1'b0;                      // R16
                            perr_q <= 1'b0;
                            prot_q <= 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave: lock and data pointer writes, reads, answers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q    <= `FCI_LOCK_RESET;
            dptr_q    <= {`FCI_AW{1'b0}};
            prdata    <= 32'h0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            rd_wait_q <= 1'b0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (setup && pwrite) begin
                pready <= 1'b1;
                case (paddr)
                    `FCI_REG_CMD:  dptr_q <= caddr;
                    `FCI_REG_DATA: dptr_q <= pwdata[`FCI_AW-1:0];
                    `FCI_REG_LOCK: lock_q <= pwdata[`FCI_NSEC-1:0];
                    default:       pslverr <= (paddr != `FCI_REG_STATUS) &&
                                              (paddr != `FCI_REG_PINS);
                endcase
            end else if (setup && !pwrite) begin
                rd_wait_q <= 1'b1;                               // array read latency
            end else if (rd_wait_q) begin
                rd_wait_q <= 1'b0;
                pready    <= 1'b1;
                prdata    <= 32'h0;
                case (paddr)
                    `FCI_REG_CMD:    prdata <= {20'h0, dptr_q};
                    `FCI_REG_STATUS: prdata <= {24'h0, status};  // R20
                    `FCI_REG_LOCK:   prdata <= {16'h0, lock_q};
                    `FCI_REG_PINS:   prdata <= {30'h0, tp_sync_q[1], op_sync_q[1]};
                    `FCI_REG_DATA: begin
                        if (rmode_q == RM_STATUS || busy)
                            prdata <= {24'h0, status};           // R8 R15
                        else if (rmode_q == RM_ID)
                            prdata <= {24'h0, (dptr_q == `FCI_ID_DEV_ADR) ?
                                       `FCI_ID_DEVICE : `FCI_ID_MAKER};    // R17
                        else
                            prdata <= {24'h0, arr_rdata};        // R1
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule
